// *** verilog/tunnel_pkg.sv ***
// Package: constants and types for the tunnel-mode host handshake
package tunnel_pkg;
    // Host command codes and inquiry reply code
    localparam logic [7:0] CMD_INQUIRY      = 8'h28;
    localparam logic [7:0] CMD_RESULT_OK    = 8'hF8;
    localparam logic [7:0] CMD_RESULT_ERR   = 8'hE8;
    localparam logic [7:0] RSP_INQUIRY      = 8'h08;
    // Reader/writer request codes
    localparam logic [7:0] RW_READ_JIS      = 8'h06;
    localparam logic [7:0] RW_READ_ISO      = 8'hB0;
    localparam logic [7:0] RW_WRITE_JIS     = 8'h08;
    localparam logic [7:0] RW_WRITE_ISO     = 8'hD6;
    // Address word layout
    localparam int         ADDR_ZERO_BIT    = 15;
    localparam int         MODE_HI          = 14;
    localparam int         MODE_LO          = 12;
    localparam logic [2:0] MODE_TUNNEL      = 3'h4;
    localparam logic [2:0] SERIAL_CLOCKED   = 3'h7;
    localparam int         SEL_HI           = 7;
    localparam int         SEL_LO           = 5;
    // Timing
    localparam int         CLOCK_HZ         = 25000000;
    localparam int         INQUIRY_COMMAND_WAIT_MS    = 100;
    localparam int         UART_WAIT_MS     = 100;
    localparam int         RESULT_WAIT_MS   = 100;
    localparam int         INQUIRY_COMMAND_WAIT_CYC   = INQUIRY_COMMAND_WAIT_MS * (CLOCK_HZ / 1000);
    localparam int         UART_WAIT_CYC    = UART_WAIT_MS * (CLOCK_HZ / 1000);
    localparam int         RESULT_WAIT_CYC  = RESULT_WAIT_MS * (CLOCK_HZ / 1000);
    localparam logic [3:0] RETRY_DEFAULT    = 4'h3;
    // AXI4-Lite register map
    localparam logic [7:0] REG_CONTROL      = 8'h00;
    localparam logic [7:0] REG_HWPARAM      = 8'h04;
    localparam logic [7:0] REG_STATUS       = 8'h08;
    localparam logic [7:0] REG_RESULT       = 8'h0C;
    localparam logic [1:0] RESP_OKAY        = 2'h0;
    localparam logic [1:0] RESP_SLVERR      = 2'h2;

    typedef enum logic [1:0] {
        REQ_NONE,
        REQ_READ,
        REQ_WRITE
    } req_kind_t;

    typedef struct packed {
        logic [7:0]  code;
        logic        iso;
        logic [11:0] start_addr;
        logic [7:0]  length;
        logic [2:0]  mode;
    } rw_req_t;
endpackage

// *** verilog/tunnel_host_handshake.sv ***
// Tunnel-mode relay between reader/writer requests and the host serial link
// Function
// - Tunnel request from reader/writer raises host attention.
// - Clocked serial attention uses only the attention pin, never data out.
// - Attention held low until host serial clock edges are seen.
// - Inquiry timeout measured from attention falling edge.
// - Asynchronous serial uses the longer of the two wait limits.
// - No attention retry after inquiry timeout on clocked serial.
// - Interface type from select pin with supply, else select default.
// - Inquiry reply carries the pending request content; here sent on clocked serial only, asynchronous serial sends no reply.
// - Address upper byte bit 7 always zero.
// - Upper-byte bits 6..4 are mode; 100 means tunnel mode.
// - Mode bits tell plaintext or encrypted exchange.
// - Asynchronous commands start timing at data field, not sync code.
// - Non-inquiry commands while waiting increment the retry counter.
// - Result wait timing starts right after first inquiry reply.
// - Time between another command and its reply excluded from result wait; here only the one ST_OTHER cycle, as no reply is sent.
// - Inquiry command byte is 0x28.
// - Result command 0xF8 normal, 0xE8 error.
// - Read request codes 0x06 or 0xB0.
// - Write request codes 0x08 or 0xD6.
// - Inquiry reply: 0x08, big-endian address, length byte.
//
// Implementation choices: the AXI4-Lite register port and the register offsets.
module tunnel_host_handshake
    import tunnel_pkg::*;
#(
    parameter int INQUIRY_COMMAND_CYC  = INQUIRY_COMMAND_WAIT_CYC,
    parameter int UART_CYC   = UART_WAIT_CYC,
    parameter int RESULT_CYC = RESULT_WAIT_CYC
) (
    // Clock and reset
    input  wire  logic        clock,
    input  wire  logic        reset_n,
    // Reader/writer request
    input  wire  logic        rw_valid,
    input  wire  rw_req_t     rw_req,
    output logic              rw_done,
    output logic              rw_error,
    // Host serial link
    input  wire  logic        serial_clk,
    input  wire  logic        serial_din,
    output logic              serial_dout,
    output logic              host_attention_request_n,
    // Async-side command strobe
    input  wire  logic        uart_cmd_valid,
    input  wire  logic [7:0]  uart_cmd,
    // Straps
    input  wire  logic        host_side_supply,
    input  wire  logic        interface_select_pin,
    // AXI4-Lite slave
    input  wire  logic [7:0]  s_axi_awaddr,
    input  wire  logic        s_axi_awvalid,
    output logic              s_axi_awready,
    input  wire  logic [31:0] s_axi_wdata,
    input  wire  logic [3:0]  s_axi_wstrb,
    input  wire  logic        s_axi_wvalid,
    output logic              s_axi_wready,
    output logic [1:0]        s_axi_bresp,
    output logic              s_axi_bvalid,
    input  wire  logic        s_axi_bready,
    input  wire  logic [7:0]  s_axi_araddr,
    input  wire  logic        s_axi_arvalid,
    output logic              s_axi_arready,
    output logic [31:0]       s_axi_rdata,
    output logic [1:0]        s_axi_rresp,
    output logic              s_axi_rvalid,
    input  wire  logic        s_axi_rready
);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WAIT_INQUIRY_COMMAND,
        ST_REPLY,
        ST_WAIT_RESULT,
        ST_OTHER,
        ST_DONE
    } state_t;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] sck_s_q;
    logic [2:0] din_s_q;
    logic       sck_q;
    logic       din_q;
    logic       sck_rise;
    logic       sck_fall;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sck_s_q <= 3'h0;
            din_s_q <= 3'h0;
            sck_q   <= 1'b0;
            din_q   <= 1'b0;
        end else begin
            sck_s_q <= {sck_s_q[1:0], serial_clk};
            din_s_q <= {din_s_q[1:0], serial_din};
            if (sck_s_q[1] == sck_s_q[2])
                sck_q <= sck_s_q[2];
            if (din_s_q[1] == din_s_q[2])
                din_q <= din_s_q[2];
        end
    end

    assign sck_rise = (sck_s_q[1] == sck_s_q[2]) && sck_s_q[2] && !sck_q;
    assign sck_fall = (sck_s_q[1] == sck_s_q[2]) && !sck_s_q[2] && sck_q;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [15:0] hwparam_q;
    logic [3:0]  retry_limit_q;
    logic        enable_q;
    logic [7:0]  last_result_q;
    logic [3:0]  retry_cnt_q;
    logic        timeout_flag_q;
    logic        clocked_mode;
    logic        clear_timeout;
    state_t      state_q;

    // Interface type from pin or default field
    assign clocked_mode = host_side_supply ? !interface_select_pin
                                           : (hwparam_q[SEL_HI:SEL_LO] == SERIAL_CLOCKED);

    // ------------------------------------------------------------
    // Serial shifter (MSB first, in on rise, out on fall)
    // ------------------------------------------------------------
    logic [7:0]  rx_shift_q;
    logic [2:0]  rx_cnt_q;
    logic        rx_byte;
    logic [7:0]  rx_data;
    logic [31:0] tx_shift_q;
    logic [5:0]  tx_left_q;
    logic        tx_load;
    logic [31:0] reply;
    rw_req_t     req_q;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rx_shift_q <= 8'h00;
            rx_cnt_q   <= 3'h0;
        end else if (sck_rise && clocked_mode) begin
            rx_shift_q <= {rx_shift_q[6:0], din_q};
            rx_cnt_q   <= rx_cnt_q + 3'h1;
        end
    end

    assign rx_byte = clocked_mode ? (sck_rise && rx_cnt_q == 3'h7) : uart_cmd_valid;
    assign rx_data = clocked_mode ? {rx_shift_q[6:0], din_q} : uart_cmd;

    // Reply: code, big-endian address, length
    assign reply = {RSP_INQUIRY, 1'b0, req_q.mode, req_q.start_addr, req_q.length};

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            tx_shift_q <= 32'h0;
            tx_left_q  <= 6'h0;
        end else if (tx_load && clocked_mode) begin
            tx_shift_q <= reply;
            tx_left_q  <= 6'h20;
        end else if (sck_fall && tx_left_q != 6'h0) begin
            tx_shift_q <= {tx_shift_q[30:0], 1'b0};
            tx_left_q  <= tx_left_q - 6'h1;
        end
    end

    // Attention only on dedicated pin, data line carries reply only
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n)
            serial_dout <= 1'b1;
        else
            serial_dout <= (tx_left_q != 6'h0) ? tx_shift_q[31] : 1'b1;
    end

    // ------------------------------------------------------------
    // Request decode and main sequence
    // ------------------------------------------------------------
    function automatic req_kind_t decode_req(input rw_req_t r);
        if ((!r.iso && r.code == RW_READ_JIS) || (r.iso && r.code == RW_READ_ISO))
            return REQ_READ;
        else if ((!r.iso && r.code == RW_WRITE_JIS) || (r.iso && r.code == RW_WRITE_ISO))
            return REQ_WRITE;
        else
            return REQ_NONE;
    endfunction

    logic [31:0] wait_cnt_q;
    logic [31:0] inquiry_command_limit;

    // Longer limit for async serial
    assign inquiry_command_limit = clocked_mode ? 32'(INQUIRY_COMMAND_CYC)
                                      : ((INQUIRY_COMMAND_CYC > UART_CYC) ? 32'(INQUIRY_COMMAND_CYC) : 32'(UART_CYC));
    assign tx_load     = (state_q == ST_WAIT_INQUIRY_COMMAND) && rx_byte && rx_data == CMD_INQUIRY;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_q        <= ST_IDLE;
            req_q          <= '0;
            wait_cnt_q     <= 32'h0;
            retry_cnt_q    <= 4'h0;
            host_attention_request_n <= 1'b1;
            rw_done        <= 1'b0;
            rw_error       <= 1'b0;
            timeout_flag_q <= 1'b0;
            last_result_q  <= 8'h00;
        end else begin
            rw_done  <= 1'b0;
            rw_error <= 1'b0;
            if (clear_timeout)
                timeout_flag_q <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (enable_q && rw_valid && decode_req(rw_req) != REQ_NONE) begin
                        req_q                    <= rw_req;
                        host_attention_request_n <= 1'b0;
                        wait_cnt_q               <= 32'h0;
                        retry_cnt_q              <= 4'h0;
                        state_q                  <= ST_WAIT_INQUIRY_COMMAND;
                    end
                end
                ST_WAIT_INQUIRY_COMMAND: begin
                    if (sck_rise)
                        host_attention_request_n <= 1'b1;
                    wait_cnt_q <= wait_cnt_q + 32'h1;
                    if (tx_load) begin
                        host_attention_request_n <= 1'b1;
                        state_q                  <= ST_REPLY;
                    end else if (rx_byte) begin
                        retry_cnt_q <= retry_cnt_q + 4'h1;
                        if (retry_cnt_q + 4'h1 >= retry_limit_q) begin
                            host_attention_request_n <= 1'b1;
                            rw_error                 <= 1'b1;
                            state_q                  <= ST_IDLE;
                        end
                    end else if (wait_cnt_q >= inquiry_command_limit - 32'h1) begin
                        // No attention retry; abandon
                        host_attention_request_n <= 1'b1;
                        timeout_flag_q           <= 1'b1;
                        rw_error                 <= 1'b1;
                        state_q                  <= ST_IDLE;
                    end
                end
                ST_REPLY: begin
                    if (!clocked_mode || tx_left_q == 6'h0) begin
                        wait_cnt_q <= 32'h0;
                        state_q    <= ST_WAIT_RESULT;
                    end
                end
                ST_WAIT_RESULT: begin
                    wait_cnt_q <= wait_cnt_q + 32'h1;
                    if (rx_byte && (rx_data == CMD_RESULT_OK || rx_data == CMD_RESULT_ERR)) begin
                        last_result_q <= rx_data;
                        rw_done       <= (rx_data == CMD_RESULT_OK);
                        rw_error      <= (rx_data == CMD_RESULT_ERR);
                        state_q       <= ST_IDLE;
                    end else if (rx_byte) begin
                        state_q <= ST_OTHER;
                    end else if (wait_cnt_q >= 32'(RESULT_CYC) - 32'h1) begin
                        timeout_flag_q <= 1'b1;
                        rw_error       <= 1'b1;
                        state_q        <= ST_IDLE;
                    end
                end
                ST_OTHER: begin
                    // Counter frozen until the reply shifter is idle; no reply is sent for the other command
                    if (!clocked_mode || tx_left_q == 6'h0)
                        state_q <= ST_WAIT_RESULT;
                end
                default: state_q <= ST_IDLE;
            endcase
            if (state_q == ST_WAIT_INQUIRY_COMMAND && wait_cnt_q >= inquiry_command_limit - 32'h1 && !rx_byte)
                timeout_flag_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    logic       aw_have_q;
    logic       w_have_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic       do_write;

    assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign do_write      = aw_have_q && w_have_q && !s_axi_bvalid;
    assign clear_timeout = do_write && aw_addr_q == REG_STATUS && w_strb_q[0] && w_data_q[0];

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            aw_addr_q     <= 8'h00;
            w_data_q      <= 32'h0;
            w_strb_q      <= 4'h0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            enable_q      <= 1'b0;
            retry_limit_q <= RETRY_DEFAULT;
            hwparam_q     <= 16'h0000;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (do_write) begin
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= RESP_OKAY;
                if (aw_addr_q == REG_CONTROL) begin
                    if (w_strb_q[0]) begin
                        enable_q      <= w_data_q[0];
                        retry_limit_q <= w_data_q[7:4];
                    end
                end else if (aw_addr_q == REG_HWPARAM) begin
                    if (w_strb_q[0]) hwparam_q[7:0]  <= w_data_q[7:0];
                    if (w_strb_q[1]) hwparam_q[15:8] <= w_data_q[15:8];
                end else if (aw_addr_q != REG_STATUS) begin
                    s_axi_bresp <= RESP_SLVERR;
                end
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            if (s_axi_araddr == REG_CONTROL)
                s_axi_rdata <= {24'h0, retry_limit_q, 3'h0, enable_q};
            else if (s_axi_araddr == REG_HWPARAM)
                s_axi_rdata <= {16'h0, hwparam_q};
            else if (s_axi_araddr == REG_STATUS)
                s_axi_rdata <= {16'h0, retry_cnt_q, 1'b0, 3'(state_q), 5'h0, clocked_mode,
                                !host_attention_request_n, timeout_flag_q};
            else if (s_axi_araddr == REG_RESULT)
                s_axi_rdata <= {24'h0, last_result_q};
            else begin
                s_axi_rdata <= 32'h0;
                s_axi_rresp <= RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_attn_on_request: assert property (@(posedge clock) disable iff (!reset_n)
        state_q == ST_IDLE && enable_q && rw_valid && decode_req(rw_req) != REQ_NONE
        |=> !host_attention_request_n)
        else $error("attention not raised on request");

    a_attn_release: assert property (@(posedge clock) disable iff (!reset_n)
        state_q == ST_WAIT_INQUIRY_COMMAND && sck_rise |=> host_attention_request_n)
        else $error("attention not released on clock");

    a_dout_idle_high: assert property (@(posedge clock) disable iff (!reset_n)
        tx_left_q == 6'h0 |=> serial_dout)
        else $error("data line used outside reply");

    a_addr_msb_zero: assert property (@(posedge clock) disable iff (!reset_n)
        tx_load && clocked_mode |=> tx_shift_q[8 + ADDR_ZERO_BIT] == 1'b0)
        else $error("address msb not zero");

    a_reply_code: assert property (@(posedge clock) disable iff (!reset_n)
        tx_load && clocked_mode |=> tx_shift_q[31:24] == RSP_INQUIRY && tx_left_q == 6'h20)
        else $error("bad inquiry reply load");

    a_inquiry_accept: assert property (@(posedge clock) disable iff (!reset_n)
        state_q == ST_WAIT_INQUIRY_COMMAND && rx_byte && rx_data == CMD_INQUIRY |=> state_q == ST_REPLY)
        else $error("inquiry not accepted");

    a_result_ok: assert property (@(posedge clock) disable iff (!reset_n)
        state_q == ST_WAIT_RESULT && rx_byte && rx_data == CMD_RESULT_OK |=> rw_done && state_q == ST_IDLE)
        else $error("normal result not completed");

    a_other_freeze: assert property (@(posedge clock) disable iff (!reset_n)
        state_q == ST_OTHER |=> $stable(wait_cnt_q))
        else $error("result wait counted during other command");

    a_retry_count: assert property (@(posedge clock) disable iff (!reset_n)
        state_q == ST_WAIT_INQUIRY_COMMAND && rx_byte && rx_data != CMD_INQUIRY
        |=> retry_cnt_q == $past(retry_cnt_q) + 4'h1)
        else $error("retry counter not advanced");

    a_result_timeout: assert property (@(posedge clock) disable iff (!reset_n)
        state_q == ST_WAIT_RESULT && !rx_byte && wait_cnt_q >= 32'(RESULT_CYC) - 32'h1
        |=> state_q == ST_IDLE && rw_error)
        else $error("result timeout not taken");

endmodule

// *** tb/host_model.sv ***
// Host controller model on the clocked serial link
module host_model (
    // Clock
    input  wire logic clock,
    // Serial link
    output logic      serial_clk,
    output logic      serial_din,
    input  wire logic serial_dout
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        serial_clk = 1'b0;
        serial_din = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask

    // Command byte MSB first, then reply bits; link clock idles low
    task automatic frame(input logic [7:0] cmd, input int nrx, output logic [31:0] rx);
        rx = '0;
        for (int i = 7; i >= 0; i--) begin
            serial_clk <= 1'b0;
            serial_din <= cmd[i];
            tick(4);
            serial_clk <= 1'b1;
            tick(4);
        end
        for (int i = 0; i < nrx; i++) begin
            serial_clk <= 1'b0;
            serial_din <= ~serial_din;
            tick(3);
            @(negedge clock);
            rx = {rx[30:0], serial_dout};
            tick(1);
            serial_clk <= 1'b1;
            tick(4);
        end
        serial_clk <= 1'b0;
        serial_din <= ~cmd[0];
    endtask
endmodule

// *** tb/tunnel_mode_host_handshake_tb.sv ***
// Testbench for the tunnel-mode host handshake
module tunnel_mode_host_handshake_tb import tunnel_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int QC = 200;
    localparam int RC = 200;
    localparam int UC = 240;
    logic        clock, reset_n, rw_valid, rw_done, rw_error, sclk, din, dout, att_n;
    logic        awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rx, d, e;
    logic [1:0]  bresp, rresp, r;
    rw_req_t     rq;
    logic        sup, sel, uv;
    logic [7:0]  uc;
    int          miscompares, num_checks, nd0, ne0;
    int          cyc = 0;
    int          n_done = 0;
    int          n_err = 0;
    logic [7:0]  codes [4] = '{RW_READ_JIS, RW_WRITE_JIS, RW_READ_ISO, RW_WRITE_ISO};

    tunnel_host_handshake #(.INQUIRY_COMMAND_CYC(QC), .UART_CYC(UC), .RESULT_CYC(RC)) u_dut (
        .clock(clock), .reset_n(reset_n), .rw_valid(rw_valid), .rw_req(rq),
        .rw_done(rw_done), .rw_error(rw_error), .serial_clk(sclk), .serial_din(din),
        .serial_dout(dout), .host_attention_request_n(att_n), .uart_cmd_valid(uv),
        .uart_cmd(uc), .host_side_supply(sup), .interface_select_pin(sel),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp),
        .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
        .s_axi_rready(rr)
    );
    host_model u_host (.clock(clock), .serial_clk(sclk), .serial_din(din), .serial_dout(dout));

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // Result pulse counters and run limit
    always @(posedge clock) begin
        cyc <= cyc + 1;
        n_done <= n_done + int'(rw_done === 1'b1);
        n_err <= n_err + int'(rw_error === 1'b1);
        if (cyc == 40000) begin
            miscompares++;
            results();
        end
    end

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] s);
        num_checks++;
        if (s !== ex) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, ex, s);
        end
    endtask

    function automatic logic [31:0] exp_reply(rw_req_t v);
        return {RSP_INQUIRY, 1'b0, v.mode, v.start_addr, v.length};
    endfunction

    task automatic axw(input logic [7:0] a, input logic [31:0] dt);
        logic da, dw;
        da = 1'b0;
        dw = 1'b0;
        awaddr <= a;
        wdata <= dt;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        while (!(da && dw)) begin
            @(negedge clock);
            if (awr === 1'b1) da = 1'b1;
            if (wr === 1'b1) dw = 1'b1;
            @(posedge clock);
            if (da) awv <= 1'b0;
            if (dw) wv <= 1'b0;
        end
        do @(negedge clock); while (bv !== 1'b1);
        @(posedge clock);
        r = bresp;
        br <= 1'b0;
        @(posedge clock);
    endtask

    task automatic axr(input logic [7:0] a);
        araddr <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        do @(negedge clock); while (arr !== 1'b1);
        @(posedge clock);
        arv <= 1'b0;
        do @(negedge clock); while (rv !== 1'b1);
        @(posedge clock);
        d = rdata;
        r = rresp;
        rr <= 1'b0;
        @(posedge clock);
    endtask

    task automatic req(input logic [7:0] code, input logic iso);
        rw_req_t v;
        v = '{code, iso, 12'($urandom), 8'($urandom), MODE_TUNNEL};
        e = exp_reply(v);
        rq <= v;
        rw_valid <= 1'b1;
        @(posedge clock);
        rw_valid <= 1'b0;
        repeat (2) @(posedge clock);
        @(negedge clock);
        chk("attention", 0, 32'(att_n));
        chk("dout idle", 1, 32'(dout));
        @(posedge clock);
    endtask

    task automatic uart(input logic [7:0] c);
        uc <= c;
        uv <= 1'b1;
        @(posedge clock);
        uv <= 1'b0;
        @(posedge clock);
    endtask

    task automatic results();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        {reset_n, rw_valid, awv, wv, br, arv, rr, uv, sel} = '0;
        {rq, awaddr, araddr, wdata, uc} = '0;
        sup = 1'b1;
        void'($urandom(91023));
        repeat (20) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        axr(REG_CONTROL);
        chk("control", 32'h30, d);
        axr(8'h40);
        chk("unmapped", 32'(RESP_SLVERR), 32'(r));
        axw(REG_HWPARAM, 32'hE0);
        sup <= 1'b0;
        axr(REG_STATUS);
        chk("default select", 1, 32'(d[2]));
        sup <= 1'b1;
        sel <= 1'b1;
        axr(REG_STATUS);
        chk("select pin", 0, 32'(d[2]));
        sel <= 1'b0;
        axw(8'h40, 32'h0);
        chk("unmapped write", 32'(RESP_SLVERR), 32'(r));
        axw(REG_CONTROL, 32'h31);
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            req(codes[i], i[1]);
            if (i == 1) begin
                u_host.frame(8'h55, 0, rx);
                axr(REG_STATUS);
                chk("retry", 1, 32'(d[15:12]));
            end
            u_host.frame(CMD_INQUIRY, 32, rx);
            chk("attention", 1, 32'(att_n));
            chk("reply", e, rx);
            nd0 = n_done;
            ne0 = n_err;
            u_host.frame(i[0] ? CMD_RESULT_ERR : CMD_RESULT_OK, 0, rx);
            repeat (8) @(posedge clock);
            chk("done", 32'(!i[0]), 32'(n_done - nd0));
            chk("error", 32'(i[0]), 32'(n_err - ne0));
            axr(REG_RESULT);
            chk("result code", 32'(i[0] ? CMD_RESULT_ERR : CMD_RESULT_OK), d);
        end
        $display("test transfers done");
        ne0 = n_err;
        req(RW_READ_JIS, 1'b0);
        repeat (QC - 12) @(posedge clock);
        chk("early timeout", 0, 32'(n_err - ne0));
        repeat (16) @(posedge clock);
        chk("inquiry timeout", 1, 32'(n_err - ne0));
        axr(REG_STATUS);
        chk("timeout flag", 1, 32'(d[0]));
        axw(REG_STATUS, 32'h1);
        axr(REG_STATUS);
        chk("flag clear", 0, 32'(d[0]));
        repeat (100) @(posedge clock);
        chk("no retry", 1, 32'(att_n));
        $display("test inquiry timeout done");
        ne0 = n_err;
        req(RW_WRITE_ISO, 1'b1);
        u_host.frame(CMD_INQUIRY, 32, rx);
        chk("reply", e, rx);
        repeat (RC - 10) @(posedge clock);
        chk("early timeout", 0, 32'(n_err - ne0));
        repeat (20) @(posedge clock);
        chk("result timeout", 1, 32'(n_err - ne0));
        $display("test result timeout done");
        sel <= 1'b1;
        req(RW_READ_JIS, 1'b0);
        nd0 = n_done;
        uart(CMD_INQUIRY);
        chk("async attention", 1, 32'(att_n));
        uart(CMD_RESULT_OK);
        repeat (4) @(posedge clock);
        chk("async done", 1, 32'(n_done - nd0));
        ne0 = n_err;
        req(RW_READ_ISO, 1'b1);
        repeat (QC + 20) @(posedge clock);
        chk("async early timeout", 0, 32'(n_err - ne0));
        repeat (30) @(posedge clock);
        chk("async timeout", 1, 32'(n_err - ne0));
        $display("test async serial done");
        results();
    end
endmodule
